// ---- flash_pin_consts.vh ----
`ifndef FLASH_PIN_CONSTS_VH
`define FLASH_PIN_CONSTS_VH

// ***************************************************
// Register byte offsets on the bus
// ***************************************************
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_STATE       8'h08
`define OFF_TXDATA      8'h0c
`define OFF_RXDATA      8'h10

// ***************************************************
// Control register fields
// ***************************************************
`define CTRL_WIDTH_LSB  0
`define CTRL_WIDTH_MSB  1
`define CTRL_DIR_OUT    2
`define CTRL_PAUSE_SEL  3
`define CTRL_RESET      4'h0

// ***************************************************
// Lane width codes
// ***************************************************
`define WIDTH_SINGLE    2'h0
`define WIDTH_DUAL      2'h1
`define WIDTH_QUAD      2'h2

// ***************************************************
// Status register fields and reset value
// ***************************************************
`define SR_BP0          2
`define SR_BP3          5
`define SR_QUAD_EN      6
`define SR_WR_LOCK      7
`define SR_GUARD_MASK   8'hfc
`define SR_RESET        8'h00

// ***************************************************
// State register fields
// ***************************************************
`define ST_RX_READY     4
`define ST_WP_REJECT    5

`endif

// ---- pin_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// ***************************************************
// Two-stage synchroniser for pin levels
// ***************************************************
module pin_sync
#(
  parameter W = 6                    // Number of pins
)
(
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_rstn,
  // Raw pin levels and settled copies
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  genvar g;

  // One pair of flops per pin; the first is read only by the second
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta_q;                    // First stage, may be metastable
      reg sync_q;                    // Second stage, safe to use
      always @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
        begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
        end
        else
        begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end
      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule // pin_sync

`default_nettype wire

// ---- status_guard.v ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_consts.vh"

// ***************************************************
// Write-protect gate for status register writes
// ***************************************************
module status_guard
(
  // Current and requested status
  input  wire [7:0] i_cur,
  input  wire [7:0] i_wdata,
  // Settled write-protect pin level
  input  wire       i_wp_level,
  // Value to store and refusal flag
  output wire [7:0] o_next,
  output wire       o_reject
);

  wire locked;                       // Guarded bits frozen

  // Lock only with the lock bit set, pin low, quad lanes off
  assign locked = i_cur[`SR_WR_LOCK] & ~i_cur[`SR_QUAD_EN] & ~i_wp_level;

  // Guarded bits keep their value while locked
  assign o_next = locked ? ((i_cur & `SR_GUARD_MASK) | (i_wdata & ~`SR_GUARD_MASK)) : i_wdata;

  // Report a refused change of a guarded bit
  assign o_reject = locked & (((i_cur ^ i_wdata) & `SR_GUARD_MASK) != 8'h00);

endmodule // status_guard

`default_nettype wire

// ---- flash_pin_if.v ----
// How it works
// - Select high: all data pins floated
// - Deselected: block rests in standby
// - Select low: block active, accepts traffic
// - Nothing accepted before first select fall
// - Input data ignored while select high
// - Single mode: capture lane zero on rise
// - Single mode: drive lane one on fall
// - Dual/quad: lanes bidirectional, rise in, fall out
// - Quad off: protect pin lane two, pause lane three
// - Lock set, protect low: guarded writes refused
// - Lock clear: status writes always allowed
// - Quad enable disables the protect function
// - Shared pin: pause or reset, pause default
// - Selector zero pause, one hardware reset
// - Quad enable removes pause and reset
// - Pause: float output, keep sequence, resume
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_consts.vh"

module flash_pin_if
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output reg         o_pslverr,
  // Serial pins
  input  wire        i_sck,
  input  wire        i_cs_n,
  input  wire [3:0]  i_data_line,
  output reg  [3:0]  o_data_line,
  output wire [3:0]  o_data_line_oe_n,
  // Block state
  output wire        o_standby,
  output wire        o_link_reset
);

  // ***************************************************
  // Link states
  // ***************************************************
  localparam [3:0] ST_STANDBY = 4'h1; // Deselected, low power
  localparam [3:0] ST_ACTIVE  = 4'h2; // Selected, moving bits
  localparam [3:0] ST_PAUSE   = 4'h4; // Selected, paused
  localparam [3:0] ST_PINRST  = 4'h8; // Held in pin reset

  // ***************************************************
  // Declarations
  // ***************************************************
  wire [5:0] pins_s;                 // Settled pin levels
  wire       sck_s;                  // Settled serial clock
  wire       cs_s;                   // Settled select, high = off
  wire [3:0] dl_s;                   // Settled data lanes
  reg        sck_d_q;                // Clock one cycle ago
  reg        cs_d_q;                 // Select one cycle ago
  wire       sck_rise;               // Capture edge
  wire       sck_fall;               // Launch edge
  wire       cs_fall;                // Start of a selection
  reg  [3:0] state_q;                // One-hot link state
  reg  [3:0] state_d;
  reg        armed_q;                // Select fall seen
  reg  [3:0] ctrl_q;                 // Width, direction, selector
  reg  [7:0] sr_q;                   // Status bits
  reg  [7:0] tx_q;                   // Byte to send
  reg  [7:0] rx_q;                   // Last byte taken
  reg  [7:0] rx_cnt_q;               // Bytes taken, wraps
  reg        rx_rdy_q;               // Sticky byte-taken flag
  reg        wp_rej_q;               // Sticky refused-write flag
  reg  [7:0] in_sh_q;                // Input shifter
  reg  [2:0] in_cnt_q;               // Bits taken of this byte
  reg  [7:0] out_sh_q;               // Output shifter
  reg  [2:0] out_cnt_q;              // Bits sent of this byte
  wire [1:0] width;                  // Effective lane width
  wire [3:0] step;                   // Bits per clock
  wire       quad_en;                // Shared pins are data lanes
  wire       pause_lvl;              // Pause pin asserted
  wire       rst_lvl;                // Reset pin asserted
  wire       active;                 // Moving bits now
  wire       drive;                  // Lanes may be driven
  reg  [7:0] in_next;                // Shifter after a capture
  wire [3:0] in_sum;                 // Count after a capture
  wire [7:0] out_src;                // Byte being shifted out
  wire [7:0] sr_next;                // Status after a gated write
  wire       sr_reject;              // Gated write refused
  wire       wr_en;                  // Bus write in access phase
  wire       rd_setup;               // Bus access, read or write, in setup phase
  reg  [31:0] rd_mux;                // Read data by address
  reg        rd_bad;                 // Unmapped address
  wire       rx_take;                // Byte completed this cycle

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  // Clock, select and lanes all come from the far side
  pin_sync #(.W(6)) u_sync
  (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_sck, i_cs_n, i_data_line}),
    .o_sync  (pins_s)
  );

  assign sck_s = pins_s[5];
  assign cs_s  = pins_s[4];
  assign dl_s  = pins_s[3:0];

  // Previous levels for edge finding
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sck_d_q <= 1'b1; // Matches the synchroniser reset, no false edge
      cs_d_q  <= 1'b1;
    end
    else
    begin
      sck_d_q <= sck_s;
      cs_d_q  <= cs_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_q;
  assign sck_fall = ~sck_s & sck_d_q;
  assign cs_fall  = ~cs_s & cs_d_q;

  // ***************************************************
  // Shared pin functions
  // ***************************************************
  assign quad_en = sr_q[`SR_QUAD_EN];

  // Quad enable strips pause and reset from lane three
  assign pause_lvl = ~quad_en & ~ctrl_q[`CTRL_PAUSE_SEL] & ~dl_s[3];
  assign rst_lvl   = ~quad_en & ctrl_q[`CTRL_PAUSE_SEL] & ~dl_s[3];

  // Quad width needs the shared pins; falls back to single otherwise
  assign width = (ctrl_q[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB] == `WIDTH_QUAD && !quad_en) ? `WIDTH_SINGLE
               : ctrl_q[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
  assign step  = (width == `WIDTH_QUAD) ? 4'h4 : (width == `WIDTH_DUAL) ? 4'h2 : 4'h1;

  // ***************************************************
  // Link state machine
  // ***************************************************
  // Pin reset outranks select; select outranks pause
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY:
      begin
        if (rst_lvl)
          state_d = ST_PINRST;
        else if (!cs_s)
          state_d = ST_ACTIVE;
      end
      ST_ACTIVE:
      begin
        if (rst_lvl)
          state_d = ST_PINRST;
        else if (cs_s)
          state_d = ST_STANDBY;
        else if (pause_lvl)
          state_d = ST_PAUSE;
      end
      ST_PAUSE:
      begin
        if (rst_lvl)
          state_d = ST_PINRST;
        else if (cs_s)
          state_d = ST_STANDBY;
        else if (!pause_lvl)
          state_d = ST_ACTIVE;
      end
      ST_PINRST:
      begin
        // Leave only to standby; a fresh select fall is needed
        if (!rst_lvl)
          state_d = ST_STANDBY;
      end
      default:
        state_d = ST_STANDBY;
    endcase
  end

  // State register
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state_q <= ST_STANDBY;
    else
      state_q <= state_d;
  end

  // Armed on a select fall, lost on any reset
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      armed_q <= 1'b0;
    else if (state_q == ST_PINRST || rst_lvl)
      armed_q <= 1'b0;
    else if (cs_fall)
      armed_q <= 1'b1;
  end

  // Standby gates all shifting; pause freezes it in place
  assign active = (state_q == ST_ACTIVE) & armed_q & ~cs_s;

  assign o_standby    = (state_q == ST_STANDBY);
  assign o_link_reset = (state_q == ST_PINRST);

  // ***************************************************
  // Capture path, rising serial clock
  // ***************************************************
  // Lane one carries the higher bit in dual; in quad lane three carries the highest
  always @*
  begin
    case (width)
      `WIDTH_QUAD: in_next = {in_sh_q[3:0], dl_s[3], dl_s[2], dl_s[1], dl_s[0]};
      `WIDTH_DUAL: in_next = {in_sh_q[5:0], dl_s[1], dl_s[0]};
      default:     in_next = {in_sh_q[6:0], dl_s[0]};
    endcase
  end

  assign in_sum  = {1'b0, in_cnt_q} + step;
  assign rx_take = active & sck_rise & ~cs_fall & in_sum[3];

  // Input shifter and count
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      in_sh_q  <= 8'h00;
      in_cnt_q <= 3'h0;
    end
    else if (cs_fall || !armed_q)
    begin
      // Partial bits from an earlier selection are dropped
      in_sh_q  <= 8'h00;
      in_cnt_q <= 3'h0;
    end
    else if (active && sck_rise)
    begin
      in_sh_q  <= in_next;
      in_cnt_q <= in_sum[2:0];
    end
  end

  // ***************************************************
  // Launch path, falling serial clock
  // ***************************************************
  // A new byte starts from the transmit register
  assign out_src = (out_cnt_q == 3'h0) ? tx_q : out_sh_q;

  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      out_sh_q    <= 8'h00;
      out_cnt_q   <= 3'h0;
      o_data_line <= 4'h0;
    end
    else if (cs_fall || !armed_q)
    begin
      out_sh_q  <= 8'h00;
      out_cnt_q <= 3'h0;
    end
    else if (active && sck_fall && ctrl_q[`CTRL_DIR_OUT])
    begin
      case (width)
        `WIDTH_QUAD:
        begin
          o_data_line <= out_src[7:4];
          out_sh_q    <= {out_src[3:0], 4'h0};
        end
        `WIDTH_DUAL:
        begin
          o_data_line <= {2'b00, out_src[7:6]};
          out_sh_q    <= {out_src[5:0], 2'b00};
        end
        default:
        begin
          o_data_line <= {2'b00, out_src[7], 1'b0};
          out_sh_q    <= {out_src[6:0], 1'b0};
        end
      endcase
      out_cnt_q <= out_cnt_q + step[2:0];
    end
  end

  // ***************************************************
  // Output enables, active low
  // ***************************************************
  // Held until synchronised select settles; a two-cycle lag on release
  assign drive = ~cs_s & armed_q & (state_q == ST_ACTIVE) & ctrl_q[`CTRL_DIR_OUT];

  assign o_data_line_oe_n[0] = ~(drive & (width != `WIDTH_SINGLE));
  assign o_data_line_oe_n[1] = ~drive;
  assign o_data_line_oe_n[2] = ~(drive & (width == `WIDTH_QUAD));
  assign o_data_line_oe_n[3] = ~(drive & (width == `WIDTH_QUAD));

  // ***************************************************
  // Status write gate
  // ***************************************************
  status_guard u_guard
  (
    .i_cur      (sr_q),
    .i_wdata    (i_pwdata[7:0]),
    .i_wp_level (dl_s[2]),
    .o_next     (sr_next),
    .o_reject   (sr_reject)
  );

  // ***************************************************
  // APB slave
  // ***************************************************
  // Zero wait states: every access completes in its first access cycle
  assign o_pready = 1'b1;
  assign wr_en    = i_psel & i_penable & i_pwrite;
  assign rd_setup = i_psel & ~i_penable;

  // Register writes and sticky flags
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_q   <= `CTRL_RESET;
      sr_q     <= `SR_RESET;
      tx_q     <= 8'h00;
      rx_q     <= 8'h00;
      rx_cnt_q <= 8'h00;
      rx_rdy_q <= 1'b0;
      wp_rej_q <= 1'b0;
    end
    else
    begin
      if (wr_en && i_paddr == `OFF_CTRL)
        ctrl_q <= i_pwdata[3:0];
      if (wr_en && i_paddr == `OFF_STATUS)
        sr_q <= sr_next;
      if (wr_en && i_paddr == `OFF_TXDATA)
        tx_q <= i_pwdata[7:0];
      // A set in the same cycle as a clear wins
      if (rx_take)
      begin
        rx_q     <= in_next;
        rx_cnt_q <= rx_cnt_q + 8'h01;
        rx_rdy_q <= 1'b1;
      end
      else if (wr_en && i_paddr == `OFF_STATE && i_pwdata[`ST_RX_READY])
        rx_rdy_q <= 1'b0;
      if (wr_en && i_paddr == `OFF_STATUS && sr_reject)
        wp_rej_q <= 1'b1;
      else if (wr_en && i_paddr == `OFF_STATE && i_pwdata[`ST_WP_REJECT])
        wp_rej_q <= 1'b0;
    end
  end

  // Read selection by address
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_bad = 1'b0;
    case (i_paddr)
      `OFF_CTRL:   rd_mux = {28'h0000000, ctrl_q};
      `OFF_STATUS: rd_mux = {24'h000000, sr_q};
      `OFF_STATE:  rd_mux = {16'h0000, rx_cnt_q, 2'b00, wp_rej_q, rx_rdy_q,
                             o_link_reset, (state_q == ST_PAUSE), armed_q, ~cs_s};
      `OFF_TXDATA: rd_mux = {24'h000000, tx_q};
      `OFF_RXDATA: rd_mux = {24'h000000, rx_q};
      default:     rd_bad = 1'b1;
    endcase
  end

  // Read data and error latched in the setup cycle
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end
    else if (rd_setup)
    begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
      o_pslverr <= rd_bad;
    end
  end

endmodule // flash_pin_if

`default_nettype wire

// ---- flash_pin_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_consts.vh"

// *****************************
// Pin behaviour checker
// *****************************
module flash_pin_props
(
  // Clock, reset and bus
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Serial pins and state
  input wire logic        i_sck,
  input wire logic        i_cs_n,
  input wire logic [3:0]  i_data_line,
  input wire logic [3:0]  o_data_line,
  input wire logic [3:0]  o_data_line_oe_n,
  input wire logic        o_standby,
  input wire logic        o_link_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  logic [3:0] ctrl_q;  // Shadow of the control word

  // Control writes are never guarded, so a shadow is exact
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      ctrl_q <= 4'h0;
    else if (i_psel && i_penable && i_pwrite && i_paddr == `OFF_CTRL)
      ctrl_q <= i_pwdata[3:0];

  a_desel_float: assert property (i_cs_n [*5] |-> o_data_line_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  a_standby_rest: assert property ((i_cs_n && !o_link_reset) [*5] |-> o_standby)
    else $error("no standby while deselected");
  a_select_wake: assert property ($fell(i_cs_n) ##1 (!i_cs_n && !o_link_reset) [*5] |-> !o_standby)
    else $error("select did not leave standby");
  a_out_on_fall: assert property ($changed(o_data_line) && !o_link_reset && !$past(o_link_reset)
    |-> !$past(i_sck, 2) && !$past(i_sck, 3))
    else $error("lane output changed off a clock fall");
  a_pause_float: assert property ((!i_cs_n && !i_data_line[3] && ctrl_q[1:0] == `WIDTH_SINGLE
    && !ctrl_q[`CTRL_PAUSE_SEL]) [*4] |-> o_data_line_oe_n[1])
    else $error("output driven during pause");
  a_pin_reset_in: assert property ((!i_data_line[3] && ctrl_q[`CTRL_PAUSE_SEL]
    && ctrl_q[1:0] != `WIDTH_QUAD && i_cs_n) [*4] |-> o_link_reset)
    else $error("shared pin low did not reset");
  a_reset_float: assert property (o_link_reset |-> o_data_line_oe_n == 4'hf)
    else $error("lanes driven in pin reset");
  a_reset_cause: assert property ($rose(o_link_reset) |-> !$past(i_data_line[3]) && !$past(i_data_line[3], 2))
    else $error("pin reset without low shared pin");
  a_unmapped_err: assert property (i_psel && i_penable && !(i_paddr inside {`OFF_CTRL, `OFF_STATUS,
    `OFF_STATE, `OFF_TXDATA, `OFF_RXDATA}) |-> o_pslverr && o_pready)
    else $error("unmapped access not refused");
endmodule // flash_pin_props

bind flash_pin_if flash_pin_props props_u (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sck, .i_cs_n, .i_data_line, .o_data_line,
  .o_data_line_oe_n, .o_standby, .o_link_reset);

`default_nettype wire

// ---- spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// *****************************
// Host controller model, mode 3
// *****************************
module spi_host_model
(
  // Clock and resolved lanes
  input  wire logic       i_clk,
  input  wire logic [3:0] i_lines,
  // Driven pins
  output var logic        o_sck,
  output var logic        o_cs_n,
  output var logic [3:0]  o_lanes
);
  logic wp_q = 1'b1;    // Protect level on lane two
  logic hold_q = 1'b1;  // Pause level on lane three

  // Clock idles high so the first fall launches bit seven
  initial
  begin
    o_sck = 1'b1;
    o_cs_n = 1'b1;
    o_lanes = 4'hc;
  end

  // Select edge first, then settle before clocking
  task sel(input logic s);
    @(posedge i_clk);
    o_cs_n <= !s;
    repeat (6) @(posedge i_clk);
  endtask

  // Set the shared pin levels
  task lvl(input logic wp, input logic hold);
    @(posedge i_clk);
    wp_q = wp;
    hold_q = hold;
    o_lanes <= {hold, wp, o_lanes[1:0]};
    repeat (3) @(posedge i_clk);
  endtask

  // Shift n clocks of w lanes, msb first
  task xfer(input logic [7:0] tx, input int w, input int n, output logic [7:0] rx);
    logic [7:0] s;
    logic [3:0] v;
    s = tx;
    rx = 8'h00;
    repeat (n)
    begin
      // Unused lanes zero and one toggle, never a stale copy; lanes two and three keep the protect and pause levels except in four-lane shifts, which carry data
      v = {hold_q, wp_q, ~o_lanes[1:0]};
      if (w == 1)
        v[0] = s[7];
      else if (w == 2)
        v[1:0] = s[7:6];
      else
        v = s[7:4];
      s = s << w;
      @(posedge i_clk);
      o_sck <= 1'b0;
      o_lanes <= v;
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      if (w == 1)
        rx = {rx[6:0], i_lines[1]};
      else if (w == 2)
        rx = {rx[5:0], i_lines[1:0]};
      else
        rx = {rx[3:0], i_lines};
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule // spi_host_model

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_pin_consts.vh"

// *****************************
// Testbench
// *****************************
module tb;
  logic        i_clk, i_rstn, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, r;
  wire  [31:0] o_prdata;
  wire         o_pready, o_pslverr, i_sck, i_cs_n, o_standby, o_link_reset;
  wire  [3:0]  i_data_line, o_data_line, o_data_line_oe_n, hl;
  logic        e;
  logic [7:0]  hrx, hrx2;
  int          n_errors = 0;
  int          n_checks = 0;

  // Lane level: device when enabled, else host
  assign i_data_line = (~o_data_line_oe_n & o_data_line) | (o_data_line_oe_n & hl);

  flash_pin_if dut_u (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_sck, .i_cs_n, .i_data_line, .o_data_line,
    .o_data_line_oe_n, .o_standby, .o_link_reset);
  spi_host_model host_u (.i_clk(i_clk), .i_lines(i_data_line), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_lanes(hl));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One bus transfer; waits for ready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge i_clk);
    end
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 50)
      n_errors++;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    apb(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask

  // Whole-byte frame; checks the side that received
  task frame(input logic [3:0] c, input logic [7:0] dtx, input logic [7:0] htx, input int w);
    wr(`OFF_CTRL, {28'h0, c});
    wr(`OFF_TXDATA, {24'h0, dtx});
    host_u.sel(1'b1);
    chk(o_standby, 32'h0);
    host_u.xfer(htx, w, 8 / w, hrx);
    host_u.sel(1'b0);
    chk({o_standby, o_data_line_oe_n}, 32'h1f);
    if (c[`CTRL_DIR_OUT])
      chk(hrx, dtx);
    else
      rd(`OFF_RXDATA, htx);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    end_sim;
  end

  // Main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    // Address and write data stay unknown until the first setup cycle
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({o_standby, o_link_reset, o_data_line_oe_n}, 32'h2f);
    rd(`OFF_CTRL, 32'h0);
    rd(`OFF_STATUS, 32'h0);
    rd(8'h14, 32'h0);
    chk(e, 32'h1);
    host_u.xfer(8'hff, 1, 8, hrx);
    rd(`OFF_STATE, 32'h0);
    frame(4'h0, 8'h00, 8'ha5, 1);
    rd(`OFF_STATE, 32'h10, 32'h10);
    host_u.xfer(8'h5a, 1, 8, hrx);
    rd(`OFF_RXDATA, 32'ha5);
    frame(4'h4, 8'h3c, 8'h00, 1);
    frame(4'h5, 8'h96, 8'h00, 2);
    frame(4'h1, 8'h00, 8'h69, 2);
    wr(`OFF_STATUS, 32'h40);
    frame(4'h6, 8'hc3, 8'h00, 4);
    frame(4'h2, 8'h00, 8'h5a, 4);
    wr(`OFF_CTRL, 32'h0a);
    host_u.lvl(1'b1, 1'b0);
    repeat (8) @(posedge i_clk);
    chk(o_link_reset, 32'h0);
    host_u.lvl(1'b1, 1'b1);
    wr(`OFF_STATUS, 32'h0);
    wr(`OFF_CTRL, 32'h08);
    host_u.lvl(1'b1, 1'b0);
    repeat (8) @(posedge i_clk);
    chk({o_link_reset, o_data_line_oe_n}, 32'h1f);
    host_u.lvl(1'b1, 1'b1);
    repeat (8) @(posedge i_clk);
    chk({o_link_reset, o_standby}, 32'h1);
    // Pause mid-byte: second half must follow on
    wr(`OFF_CTRL, 32'h04);
    wr(`OFF_TXDATA, 32'he7);
    host_u.sel(1'b1);
    host_u.xfer(8'h00, 1, 4, hrx);
    host_u.lvl(1'b1, 1'b0);
    // The pause state lands on the edge that ends the task; look once settled
    @(negedge i_clk);
    chk(o_data_line_oe_n[1], 32'h1);
    host_u.xfer(8'h00, 1, 4, hrx2);
    host_u.lvl(1'b1, 1'b1);
    host_u.xfer(8'h00, 1, 4, hrx2);
    host_u.sel(1'b0);
    chk({hrx[3:0], hrx2[3:0]}, 32'he7);
    // Partial byte then a fresh frame
    wr(`OFF_CTRL, 32'h0);
    host_u.sel(1'b1);
    host_u.xfer(8'hf0, 1, 3, hrx);
    host_u.sel(1'b0);
    frame(4'h0, 8'h00, 8'h3c, 1);
    // Status write guard
    host_u.lvl(1'b0, 1'b1);
    wr(`OFF_STATUS, 32'h80);
    rd(`OFF_STATUS, 32'h80);
    wr(`OFF_STATUS, 32'h3f);
    rd(`OFF_STATUS, 32'h83);
    rd(`OFF_STATE, 32'h20, 32'h20);
    host_u.lvl(1'b1, 1'b1);
    wr(`OFF_STATUS, 32'h3c);
    rd(`OFF_STATUS, 32'h3c);
    wr(`OFF_STATUS, 32'hc0);
    host_u.lvl(1'b0, 1'b1);
    wr(`OFF_STATUS, 32'h04);
    rd(`OFF_STATUS, 32'h04);
    end_sim;
  end
endmodule // tb

`default_nettype wire
